// >>> src/vpic_top.sv
// Vectored priority interrupt controller with its Avalon-MM register file.
`timescale 1ns/100ps
`include "vpic_defs.svh"
module vpic_top (
    input  wire logic                 CLK,
    input  wire logic                 RESET,
    input  wire logic [7:0]           AVS_ADDRESS,
    input  wire logic                 AVS_READ,
    input  wire logic                 AVS_WRITE,
    input  wire logic [31:0]          AVS_WRITEDATA,
    output logic      [31:0]          AVS_READDATA,
    output logic                      AVS_WAITREQUEST,
    input  wire logic [71:0]          SRC_REQ,
    input  wire logic [5:1]           TRAP_REQ,
    output logic                      INT_REQ,
    output vpic_pkg::vpic_vec_t       INT_VECTOR,
    output vpic_pkg::vpic_lvl_t       INT_LEVEL,
    output logic      [8:0]           INT_SLOT,
    input  wire logic                 INT_ACK,
    input  wire logic                 CORE_RESTORE,
    input  wire vpic_pkg::vpic_lvl_t  CORE_RESTORE_LEVEL,
    output vpic_pkg::vpic_lvl_t       CORE_LEVEL,
    output logic      [4:0]           EXT_EDGE_POL,
    output logic                      IRQ
);
    import vpic_pkg::*;

    vpic_bus_t    bus_q;
    logic [5:0]   idx;
    logic         wr_fire;
    logic [15:0]  wdata;
    logic [31:0]  rd_d;
    logic [31:0]  rdata_q;
    logic [79:0]  flags_q;
    logic [79:0]  en_q;
    logic [215:0] prio_q;
    logic [15:1]  gc1_q;
    logic         alt_q;
    logic [4:0]   pol_q;
    vpic_lvl_t    ipl_q;
    logic [7:0]   trap_pend_q;
    logic [1:0]   evt_sts_q;
    logic [1:0]   evt_mask_q;
    logic [1:0]   evt_set;
    logic         pend_valid_q;
    vpic_vec_t    pend_vec_q;
    vpic_lvl_t    pend_lvl_q;
    logic [8:0]   slot_q;
    logic         irq_q;
    logic         take;
    logic         take_trap;
    logic [7:1]   trap_sts_set;
    logic [79:0]  src_ext;

    // Positions 72 to 79 are reserved and can never hold a flag or an enable.
    localparam logic [79:0] src_valid = `VPIC_SRC_VALID;

    // Request lines widened to the five 16-bit banks.
    assign src_ext = {8'h00, SRC_REQ};

    // True when the accepted write targets the given register index.
    function automatic logic hit(input logic f, input logic [5:0] a, input logic [5:0] ix);
        return f && (a == ix);
    endfunction

    assign idx     = AVS_ADDRESS[7:2];
    assign wdata   = AVS_WRITEDATA[15:0];
    assign wr_fire = AVS_WRITE && (bus_q == VPIC_BUS_DONE);

    // Every access waits one cycle; the answer stands in the second cycle.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            bus_q <= VPIC_BUS_IDLE;
        end else begin
            case (bus_q)
                VPIC_BUS_IDLE: begin
                    if (AVS_READ || AVS_WRITE) begin
                        bus_q <= VPIC_BUS_DONE;
                    end
                end
                VPIC_BUS_DONE: bus_q <= VPIC_BUS_IDLE;
                default:       bus_q <= VPIC_BUS_IDLE;
            endcase
        end
    end

    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && (bus_q == VPIC_BUS_IDLE);

    // Flag banks: a source pulse wins over a software clear.
    generate
        for (genvar b = 0; b < 5; b++) begin : g_flag
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    flags_q[b*16 +: 16] <= 16'h0000;
                end else begin
                    flags_q[b*16 +: 16] <= ((hit(wr_fire, idx, 6'(`VPIC_IX_FLAG + b))
                        ? wdata : flags_q[b*16 +: 16])
                        | src_ext[b*16 +: 16])
                        & src_valid[b*16 +: 16];
                end
            end
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    en_q[b*16 +: 16] <= 16'h0000;
                end else if (hit(wr_fire, idx, 6'(`VPIC_IX_EN + b))) begin
                    en_q[b*16 +: 16] <= wdata & src_valid[b*16 +: 16];
                end
            end
        end
    endgenerate

    // Priority banks: four 3-bit fields per register, bit 3 of each nibble unused.
    generate
        for (genvar r = 0; r < 18; r++) begin : g_prio
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    prio_q[r*12 +: 12] <= 12'h000;
                end else if (hit(wr_fire, idx, 6'(`VPIC_IX_PRIO + r))) begin
                    for (int s = 0; s < 4; s++) begin
                        prio_q[r*12 + s*3 +: 3] <= wdata[s*4 +: 3];
                    end
                end
            end
        end
    endgenerate

    // Hardware trap events map onto their status bits in the first control word.
    always_comb begin
        trap_sts_set = 7'h00;
        trap_sts_set[1] = TRAP_REQ[`VPIC_T_OSC];
        trap_sts_set[3] = TRAP_REQ[`VPIC_T_ADDR];
        trap_sts_set[2] = TRAP_REQ[`VPIC_T_STK];
        trap_sts_set[4] = TRAP_REQ[`VPIC_T_MATH];
        trap_sts_set[5] = TRAP_REQ[`VPIC_T_DMA];
    end

    // First global control word: nesting disable and trap status.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            gc1_q <= 15'h0000;
        end else begin
            if (hit(wr_fire, idx, `VPIC_IX_GC1)) begin
                gc1_q <= wdata[15:1] | {8'h00, trap_sts_set};
            end else begin
                gc1_q <= gc1_q | {8'h00, trap_sts_set};
            end
        end
    end

    // Second global control word: table select and external edge polarity.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            alt_q <= 1'b0;
            pol_q <= 5'h00;
        end else if (hit(wr_fire, idx, `VPIC_IX_GC2)) begin
            alt_q <= wdata[`VPIC_ALT_BIT];
            pol_q <= wdata[4:0];
        end
    end

    assign take      = INT_ACK && pend_valid_q;
    assign take_trap = take && pend_lvl_q[`VPIC_CORE_PRIORITY_TOP_BIT_BIT];

    // Core priority level: accept, then restore, then software access.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ipl_q <= 4'h0;
        end else if (take) begin
            if (gc1_q[`VPIC_NESTING_DISABLE_BIT] && !pend_lvl_q[`VPIC_CORE_PRIORITY_TOP_BIT_BIT]) begin
                ipl_q <= `VPIC_NEST_LVL;
            end else begin
                ipl_q <= pend_lvl_q;
            end
        end else if (CORE_RESTORE) begin
            ipl_q <= CORE_RESTORE_LEVEL;
        end else begin
            if (hit(wr_fire, idx, `VPIC_IX_CSW) && !gc1_q[`VPIC_NESTING_DISABLE_BIT]) begin
                ipl_q[2:0] <= wdata[`VPIC_IPL_LO +: 3];
            end
            if (hit(wr_fire, idx, `VPIC_IX_CCW) && !wdata[`VPIC_CORE_PRIORITY_TOP_BIT_BIT]) begin
                ipl_q[3] <= 1'b0;
            end
        end
    end

    // Trap requests stay pending until the core accepts that trap.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            trap_pend_q <= 8'h00;
        end else begin
            for (int v = `VPIC_T_OSC; v <= `VPIC_T_DMA; v++) begin
                if (TRAP_REQ[v]) begin
                    trap_pend_q[v] <= 1'b1;
                end else if (take_trap && pend_vec_q == 7'(v)) begin
                    trap_pend_q[v] <= 1'b0;
                end
            end
        end
    end

    vpic_arb_if arb_if ();

    assign arb_if.flags     = flags_q[71:0];
    assign arb_if.enables   = en_q[71:0];
    assign arb_if.prio      = prio_q;
    assign arb_if.trap_pend = trap_pend_q;
    assign arb_if.cur_level = ipl_q;

    vpic_arbiter u_arb (
        .arb (arb_if)
    );

    // Latch the winner; drop it for one cycle after an accept so the new level applies.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pend_valid_q <= 1'b0;
            pend_vec_q   <= 7'h00;
            pend_lvl_q   <= 4'h0;
            slot_q       <= 9'h000;
        end else begin
            pend_valid_q <= arb_if.found && !take;
            if (arb_if.found) begin
                pend_vec_q <= arb_if.vector;
                pend_lvl_q <= arb_if.level;
                slot_q     <= `VPIC_IVT_BASE + {1'b0, arb_if.vector, 1'b0}
                              + (alt_q ? `VPIC_ALTERNATE_VECTOR_TABLE_OFS : 9'h000);
            end
        end
    end

    // Event status: bit 0 any accept, bit 1 trap accept; write one to clear.
    assign evt_set = {take_trap, take};

    always_ff @(posedge CLK) begin
        if (RESET) begin
            evt_sts_q <= 2'h0;
        end else if (hit(wr_fire, idx, `VPIC_IX_EVST)) begin
            evt_sts_q <= (evt_sts_q & ~wdata[1:0]) | evt_set;
        end else begin
            evt_sts_q <= evt_sts_q | evt_set;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            evt_mask_q <= 2'h0;
        end else if (hit(wr_fire, idx, `VPIC_IX_EVMSK)) begin
            evt_mask_q <= wdata[1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_sts_q & evt_mask_q);
        end
    end

    // Read decode over the thirty controller registers and the extras.
    always_comb begin
        rd_d = 32'h0000_0000;
        case (idx)
            `VPIC_IX_GC1:   rd_d[15:0] = {gc1_q, 1'b0};
            `VPIC_IX_GC2:   rd_d[15:0] = {alt_q, 10'h000, pol_q};
            `VPIC_IX_PEND:  rd_d[15:0] = {4'h0, pend_lvl_q, 1'b0, pend_vec_q};
            `VPIC_IX_CSW:   rd_d[15:0] = {8'h00, ipl_q[2:0], 5'h00};
            `VPIC_IX_CCW:   rd_d[15:0] = {12'h000, ipl_q[3], 3'h0};
            `VPIC_IX_EVST:  rd_d[1:0]  = evt_sts_q;
            `VPIC_IX_EVMSK: rd_d[1:0]  = evt_mask_q;
            default: begin
                for (int b = 0; b < 5; b++) begin
                    if (idx == 6'(`VPIC_IX_FLAG + b)) begin
                        rd_d[15:0] = flags_q[b*16 +: 16];
                    end
                    if (idx == 6'(`VPIC_IX_EN + b)) begin
                        rd_d[15:0] = en_q[b*16 +: 16];
                    end
                end
                for (int r = 0; r < 18; r++) begin
                    if (idx == 6'(`VPIC_IX_PRIO + r)) begin
                        for (int s = 0; s < 4; s++) begin
                            rd_d[s*4 +: 3] = prio_q[r*12 + s*3 +: 3];
                        end
                    end
                end
            end
        endcase
    end

    // Read data is captured in the waiting cycle and stands while waitrequest is low.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_q == VPIC_BUS_IDLE && AVS_READ) begin
            rdata_q <= rd_d;
        end
    end

    assign AVS_READDATA = rdata_q;
    assign INT_REQ      = pend_valid_q;
    assign INT_VECTOR   = pend_vec_q;
    assign INT_LEVEL    = pend_lvl_q;
    assign INT_SLOT     = slot_q;
    assign CORE_LEVEL   = ipl_q;
    assign EXT_EDGE_POL = pol_q;
    assign IRQ          = irq_q;

    // Checks on the controller's own behaviour.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    vector_map_a: assert property (INT_REQ && !INT_LEVEL[3] |->
        INT_SLOT == `VPIC_IVT_BASE + {1'b0, INT_VECTOR, 1'b0}
        + ($past(alt_q) ? `VPIC_ALTERNATE_VECTOR_TABLE_OFS : 9'h000))
        else $error("slot does not match vector");
    reserved_src_a: assert property (INT_REQ && !INT_LEVEL[3] |->
        INT_VECTOR >= 7'h08 && INT_VECTOR <= 7'h4F)
        else $error("user vector out of range");
    trap_vec_a: assert property (INT_REQ && INT_LEVEL[3] |->
        INT_VECTOR >= 7'h01 && INT_VECTOR <= 7'h05)
        else $error("trap vector out of range");
    flag_hold_a: assert property (flags_q[0] && !hit(wr_fire, idx, `VPIC_IX_FLAG)
        |=> flags_q[0])
        else $error("flag lost without a write");
    enable_gate_a: assert property (arb_if.found && !arb_if.level[3] |->
        en_q[arb_if.vector - 7'h08])
        else $error("disabled source presented");
    ack_level_a: assert property (take && !gc1_q[15] && !CORE_RESTORE
        |=> ipl_q == $past(INT_LEVEL))
        else $error("level not taken on accept");
    top_bit_a: assert property (!ipl_q[3] && !take && !CORE_RESTORE
        |=> !ipl_q[3])
        else $error("top level bit set by software");
    user_block_a: assert property (ipl_q[3] |=> !(INT_REQ && !INT_LEVEL[3]))
        else $error("user interrupt while top bit set");
    nest_lock_a: assert property (gc1_q[15] && !take && !CORE_RESTORE
        |=> ipl_q[2:0] == $past(ipl_q[2:0]))
        else $error("level bits changed under nest disable");
    level_above_a: assert property (INT_REQ |-> INT_LEVEL > $past(ipl_q))
        else $error("pending level not above core level");
    irq_line_a: assert property (|(evt_sts_q & evt_mask_q) |=> IRQ)
        else $error("masked event did not raise IRQ");

    accept_user_c: cover property (take && !pend_lvl_q[3]);
    accept_trap_c: cover property (take_trap);
    alt_table_c: cover property (INT_REQ && alt_q);
endmodule

// >>> include/vpic_defs.svh
// Constants for the vectored priority interrupt controller.
`ifndef VPIC_DEFS_SVH
`define VPIC_DEFS_SVH
`define VPIC_NSRC       72
`define VPIC_SRC_VALID  80'h00FF_FFFF_FFFF_FFFF_FFFF
`define VPIC_VEC_OFS    7'h08
`define VPIC_IVT_BASE   9'h004
`define VPIC_ALTERNATE_VECTOR_TABLE_OFS   9'h100
`define VPIC_NEST_LVL   4'h7
`define VPIC_TRAP_TOP   4'hF
`define VPIC_IX_GC1     6'h00
`define VPIC_IX_GC2     6'h01
`define VPIC_IX_FLAG    6'h02
`define VPIC_IX_EN      6'h07
`define VPIC_IX_PRIO    6'h0C
`define VPIC_IX_PEND    6'h1E
`define VPIC_IX_CSW     6'h1F
`define VPIC_IX_CCW     6'h20
`define VPIC_IX_EVST    6'h21
`define VPIC_IX_EVMSK   6'h22
`define VPIC_NESTING_DISABLE_BIT 15
`define VPIC_ALT_BIT    15
`define VPIC_IPL_LO     5
`define VPIC_CORE_PRIORITY_TOP_BIT_BIT   3
`define VPIC_T_OSC      1
`define VPIC_T_STK      3
`define VPIC_T_ADDR     2
`define VPIC_T_MATH     4
`define VPIC_T_DMA      5
`endif

// >>> include/vpic_pkg.sv
// Types shared by the interrupt controller modules.
package vpic_pkg;
    typedef logic [3:0] vpic_lvl_t;
    typedef logic [6:0] vpic_vec_t;
    typedef enum logic [0:0] {
        VPIC_BUS_IDLE = 1'b0,
        VPIC_BUS_DONE = 1'b1
    } vpic_bus_t;
endpackage

// >>> include/vpic_arb_if.sv
// Signals between the register file and the priority arbiter.
`timescale 1ns/100ps
interface vpic_arb_if;
    logic [71:0]          flags;
    logic [71:0]          enables;
    logic [215:0]         prio;
    logic [7:0]           trap_pend;
    vpic_pkg::vpic_lvl_t  cur_level;
    logic                 found;
    vpic_pkg::vpic_vec_t  vector;
    vpic_pkg::vpic_lvl_t  level;
    modport arb (input flags, enables, prio, trap_pend, cur_level,
                 output found, vector, level);
    modport ctl (output flags, enables, prio, trap_pend, cur_level,
                 input found, vector, level);
endinterface

// >>> src/vpic_arbiter.sv
// Priority arbiter: picks the highest pending trap or user source.
`timescale 1ns/100ps
`include "vpic_defs.svh"
module vpic_arbiter (
    vpic_arb_if.arb arb
);
    import vpic_pkg::*;

    // Returns the 3-bit priority field of one source.
    function automatic logic [2:0] src_prio(input logic [215:0] p, input int i);
        return p[i*3 +: 3];
    endfunction

    vpic_lvl_t best;
    vpic_vec_t vec;

    // Scan upward with a strict compare so the lowest request wins a tie.
    always_comb begin
        best = arb.cur_level;
        vec  = '0;
        if (!arb.cur_level[`VPIC_CORE_PRIORITY_TOP_BIT_BIT]) begin
            for (int i = 0; i < `VPIC_NSRC; i++) begin
                if (arb.flags[i] && arb.enables[i]
                    && {1'b0, src_prio(arb.prio, i)} > best) begin
                    best = {1'b0, src_prio(arb.prio, i)};
                    vec  = 7'(i) + `VPIC_VEC_OFS;
                end
            end
        end
        // Traps sit above every user level; vector 1 is the most urgent.
        for (int v = `VPIC_T_OSC; v <= `VPIC_T_DMA; v++) begin
            if (arb.trap_pend[v] && (`VPIC_TRAP_TOP - 4'(v)) > best) begin
                best = `VPIC_TRAP_TOP - 4'(v);
                vec  = 7'(v);
            end
        end
    end

    assign arb.found  = (best != arb.cur_level);
    assign arb.vector = vec;
    assign arb.level  = best;
endmodule

// >>> sim/vpic_core_model.sv
// Behavioural processor core that accepts offered vectors after a chosen delay.
`timescale 1ns/100ps
module vpic_core_model (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                int_req,
    input  wire vpic_pkg::vpic_vec_t int_vector,
    input  wire logic                ack_en,
    input  wire logic [3:0]          ack_dly,
    output logic                     int_ack,
    output vpic_pkg::vpic_vec_t      last_vec,
    output logic [7:0]               acc_cnt
);
    import vpic_pkg::*;
    logic [3:0] wait_q;

    // Waits while an offer stands, then accepts it with a single-cycle pulse.
    always_ff @(posedge clk) begin
        if (reset) begin
            int_ack  <= 1'b0;
            last_vec <= 7'h00;
            acc_cnt  <= 8'h00;
            wait_q   <= 4'h0;
        end else begin
            int_ack <= 1'b0;
            if (!int_req || !ack_en) begin
                wait_q <= 4'h0;
            end else if (!int_ack && wait_q >= ack_dly) begin
                int_ack  <= 1'b1;
                last_vec <= int_vector;
                acc_cnt  <= acc_cnt + 8'h01;
                wait_q   <= 4'h0;
            end else if (!int_ack) begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the vectored priority interrupt controller.
`timescale 1ns/100ps
`include "vpic_defs.svh"
module tb;
    import vpic_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic        rd_s = 1'b0;
    logic        wr_s = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        waitreq;
    logic [71:0] src = '0;
    logic [5:1]  trap = 5'h00;
    logic        int_req;
    vpic_vec_t   int_vector;
    vpic_lvl_t   int_level;
    logic [8:0]  int_slot;
    logic        int_ack;
    logic        core_rst = 1'b0;
    vpic_lvl_t   rst_lvl = 4'h0;
    vpic_lvl_t   core_level;
    logic [4:0]  edge_pol;
    logic        irq;
    logic        ack_en = 1'b0;
    logic [3:0]  ack_dly = 4'h0;
    vpic_vec_t   last_vec;
    logic [7:0]  acc_cnt;
    int          miscompares = 0;
    int          checks_done = 0;
    int          m_prio [80];
    bit          m_en [80];
    bit          m_mask = 1'b1;
    bit          m_alt = 1'b0;
    int          exp_q [$];
    logic [15:0] rd;
    int          tbit [6] = '{0, 1, 3, 2, 4, 5};
    int          ridx [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 30, 31, 32, 33};
    int          i;
    int          n;
    int          p;

    // The clock toggles every 2.5 ns, half of its 5 ns period.
    always #2.5 clk = ~clk;

    vpic_top i_vpic_top (.CLK(clk), .RESET(reset), .AVS_ADDRESS(addr), .AVS_READ(rd_s),
        .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .SRC_REQ(src), .TRAP_REQ(trap), .INT_REQ(int_req),
        .INT_VECTOR(int_vector), .INT_LEVEL(int_level), .INT_SLOT(int_slot),
        .INT_ACK(int_ack), .CORE_RESTORE(core_rst), .CORE_RESTORE_LEVEL(rst_lvl),
        .CORE_LEVEL(core_level), .EXT_EDGE_POL(edge_pol), .IRQ(irq));

    vpic_core_model i_vpic_core_model (.clk(clk), .reset(reset), .int_req(int_req),
        .int_vector(int_vector), .ack_en(ack_en), .ack_dly(ack_dly), .int_ack(int_ack),
        .last_vec(last_vec), .acc_cnt(acc_cnt));

    // Prints the counts and the verdict, then stops the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one and counts both outcomes.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A wait that ran out of its bound ends the run as a mismatch.
    task automatic hang();
        chk(32'h0, 32'h1);
        final_report();
    endtask

    // One register transfer, held until waitrequest is sampled low.
    task automatic bus(input bit wr, input int idx, input logic [15:0] wd);
        addr  <= 8'(idx * 4);
        wdata <= {16'h0000, wd};
        wr_s  <= wr;
        rd_s  <= !wr;
        @(posedge clk);
        for (int k = 0; waitreq !== 1'b0; k++) begin
            if (k == 20) hang();
            @(posedge clk);
        end
        rd = rdata[15:0];
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rchk(input int idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0000);
        chk(32'(rd), 32'(exp));
    endtask

    // Writes the enable bank and priority register that hold source s.
    task automatic load_src(input int s);
        logic [15:0] w;
        w = '0;
        for (int b = 0; b < 16; b++) w[b] = m_en[(s / 16) * 16 + b];
        bus(1'b1, `VPIC_IX_EN + s / 16, w);
        w = '0;
        for (int b = 0; b < 4; b++) w[b * 4 +: 3] = 3'(m_prio[(s / 4) * 4 + b]);
        bus(1'b1, `VPIC_IX_PRIO + s / 4, w);
    endtask

    // Enables source s at priority pr and pulses its request line.
    task automatic raise(input int s, input int pr);
        m_en[s] = 1'b1;
        m_prio[s] = pr;
        load_src(s);
        src[s] <= 1'b1;
        @(posedge clk);
        src <= '0;
    endtask

    task automatic restore();
        core_rst <= 1'b1;
        rst_lvl  <= 4'h0;
        @(posedge clk);
        core_rst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic drop(input int s);
        m_en[s] = 1'b0;
        load_src(s);
        bus(1'b1, `VPIC_IX_FLAG + s / 16, 16'h0000);
        restore();
    endtask

    // Checks the offer, lets the core accept it and checks level and events.
    task automatic take(input int vec, input int lvl, input int nl);
        int c;
        for (int k = 0; int_req !== 1'b1; k++) begin
            if (k == 40) hang();
            @(posedge clk);
        end
        chk(32'(int_vector), vec);
        chk(32'(int_level), lvl);
        chk(32'(int_slot), 4 + 2 * vec + (m_alt ? 256 : 0));
        rchk(`VPIC_IX_PEND, 16'(lvl * 256 + vec));
        exp_q.push_back(vec);
        c = acc_cnt;
        ack_dly <= 4'($urandom_range(0, 3));
        ack_en  <= 1'b1;
        for (int k = 0; acc_cnt === 8'(c); k++) begin
            if (k == 40) hang();
            @(posedge clk);
        end
        ack_en <= 1'b0;
        @(posedge clk);
        chk(32'(last_vec), exp_q.pop_front());
        chk(32'(core_level), nl);
        @(posedge clk);
        chk(32'(irq), 32'(m_mask));
        rchk(`VPIC_IX_EVST, (vec < 8) ? 16'h0003 : 16'h0001);
        bus(1'b1, `VPIC_IX_EVST, 16'h0003);
        @(posedge clk);
        chk(32'(irq), 32'h0);
    endtask

    // Main sequence: reset values, vector map, masking, nesting and traps.
    initial begin
        void'($urandom(32'h0ebffc12));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        foreach (ridx[j]) rchk(ridx[j], 16'h0000);
        bus(1'b1, 63, 16'hFFFF);
        rchk(63, 16'h0000);
        bus(1'b1, `VPIC_IX_GC1, 16'hFFFF);
        rchk(`VPIC_IX_GC1, 16'hFFFE);
        bus(1'b1, `VPIC_IX_GC1, 16'h0000);
        bus(1'b1, `VPIC_IX_GC2, 16'hFFFF);
        rchk(`VPIC_IX_GC2, 16'h801F);
        chk(32'(edge_pol), 32'h1F);
        bus(1'b1, `VPIC_IX_GC2, 16'h0000);
        bus(1'b1, `VPIC_IX_FLAG + 4, 16'hFFFF);
        bus(1'b0, `VPIC_IX_FLAG + 4, 16'h0000);
        chk(32'(rd[15:8]), 32'h0);
        bus(1'b1, `VPIC_IX_FLAG + 4, 16'h0000);
        // Boundary and random sources through both tables, last one masked.
        for (i = 0; i < 8; i++) begin
            n = (i == 0) ? 0 : (i == 1) ? 46 : (i == 2) ? 71 : $urandom_range(1, 70);
            p = $urandom_range(1, 7);
            m_mask = (i != 7);
            m_alt = (i % 2 == 1);
            bus(1'b1, `VPIC_IX_EVMSK, {14'h0, m_mask, m_mask});
            bus(1'b1, `VPIC_IX_GC2, {m_alt, 15'h0000});
            raise(n, p);
            take(n + 8, p, p);
            drop(n);
        end
        m_alt = 1'b0;
        m_mask = 1'b1;
        bus(1'b1, `VPIC_IX_GC2, 16'h0000);
        bus(1'b1, `VPIC_IX_EVMSK, 16'h0003);
        // A flagged source with its enable clear stays hidden.
        src[33] <= 1'b1;
        @(posedge clk);
        src <= '0;
        repeat (8) @(posedge clk);
        chk(32'(int_req), 32'h0);
        rchk(`VPIC_IX_FLAG + 2, 16'h0002);
        bus(1'b1, `VPIC_IX_FLAG + 2, 16'h0000);
        rchk(`VPIC_IX_FLAG + 2, 16'h0000);
        // Equal priorities raised together: the lowest number wins.
        m_en[6] = 1'b1;
        m_prio[6] = 2;
        m_en[10] = 1'b1;
        m_prio[10] = 3;
        m_en[5] = 1'b1;
        m_prio[5] = 3;
        load_src(10);
        load_src(5);
        src <= (72'h1 << 5) | (72'h1 << 6) | (72'h1 << 10);
        @(posedge clk);
        src <= '0;
        take(13, 3, 3);
        m_en[6] = 1'b0;
        m_en[10] = 1'b0;
        drop(5);
        // Software level 5 blocks priority 5 until lowered to 4.
        bus(1'b1, `VPIC_IX_CSW, 16'h00A0);
        @(posedge clk);
        chk(32'(core_level), 32'h5);
        rchk(`VPIC_IX_CSW, 16'h00A0);
        raise(40, 5);
        repeat (8) @(posedge clk);
        chk(32'(int_req), 32'h0);
        bus(1'b1, `VPIC_IX_CSW, 16'h0080);
        take(48, 5, 5);
        drop(40);
        // Nesting disabled: level bits frozen and no preemption.
        bus(1'b1, `VPIC_IX_GC1, 16'h8000);
        bus(1'b1, `VPIC_IX_CSW, 16'h0060);
        @(posedge clk);
        chk(32'(core_level), 32'h0);
        raise(17, 2);
        take(25, 2, 7);
        raise(18, 6);
        repeat (8) @(posedge clk);
        chk(32'(int_req), 32'h0);
        m_en[17] = 1'b0;
        drop(18);
        bus(1'b1, `VPIC_IX_GC1, 16'h0000);
        bus(1'b1, `VPIC_IX_CCW, 16'h0008);
        @(posedge clk);
        chk(32'(core_level), 32'h0);
        // Every trap, with user sources blocked while the top bit is set.
        for (i = 1; i < 6; i++) begin
            trap[i] <= 1'b1;
            @(posedge clk);
            trap <= 5'h00;
            take(i, 15 - i, 15 - i);
            rchk(`VPIC_IX_GC1, 16'(1 << tbit[i]));
            rchk(`VPIC_IX_CCW, 16'h0008);
            if (i == 1) begin
                raise(20, 7);
                repeat (8) @(posedge clk);
                chk(32'(int_req), 32'h0);
                bus(1'b1, `VPIC_IX_CCW, 16'h0000);
                @(posedge clk);
                chk(32'(core_level), 32'h6);
                take(28, 7, 7);
                drop(20);
            end
            bus(1'b1, `VPIC_IX_GC1, 16'h0000);
            restore();
        end
        final_report();
    end
endmodule
